// ===== hdl/bwp_regs.vh
// bwp_regs.vh: register offsets, field positions and reset values
// assumes: included by the parity report block, byte addresses on a 32-bit wishbone
`ifndef BWP_REGS_VH
`define BWP_REGS_VH

// register byte offsets
`define BWP_ADDR_CTRL 8'h00
`define BWP_ADDR_STATUS 8'h04
`define BWP_ADDR_IRQ_MASK 8'h08
`define BWP_ADDR_EVENTS 8'h0c

// control bits
`define BWP_CTRL_PRI_PER_EN 0
`define BWP_CTRL_SEC_PER_EN 1
`define BWP_CTRL_SERR_EN 2
`define BWP_CTRL_PW_SERR_DIS 3
`define BWP_CTRL_W 4

// status bits
`define BWP_ST_PRI_DET 0
`define BWP_ST_SEC_DET 1
`define BWP_ST_PRI_MDPD 2
`define BWP_ST_SEC_MDPD 3
`define BWP_ST_SIG_SERR 4
`define BWP_ST_W 5

// reset values
`define BWP_CTRL_RESET 4'h0
`define BWP_STATUS_RESET 5'h00
`define BWP_MASK_RESET 5'h00

// parity error pin delay after the data phase, in clocks
`define BWP_PERR_DELAY 2

`endif

// ===== hdl/bwp_parity_report.v
// bwp_parity_report.v: data parity detection, forwarding and report logic of a
// two-port bridge for posted and delayed writes and reads in both directions.
// assumes: transaction decode comes from same-clock bridge logic; the two
// parity error pins arrive from the buses and are synchronised here.
`timescale 1ns/10ps
`include "bwp_regs.vh"

module bwp_parity_report (
    input wire i_mclk,
    input wire i_reset_n,
    // wishbone classic slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // primary data phase: valid, bad parity seen, direction, transaction type
    input wire i_pri_phase,
    input wire i_pri_par_bad,
    input wire i_pri_bridge_master,
    input wire i_pri_is_write,
    input wire i_pri_fwd_bad,
    // secondary data phase
    input wire i_sec_phase,
    input wire i_sec_par_bad,
    input wire i_sec_bridge_master,
    input wire i_sec_is_write,
    input wire i_sec_fwd_bad,
    // parity error pins as seen from the buses
    input wire i_primary_parity_err_n,
    input wire i_secondary_parity_err_n,
    // pin drives
    output reg o_primary_parity_err_n,
    output reg o_primary_parity_err_oe,
    output reg o_secondary_parity_err_n,
    output reg o_secondary_parity_err_oe,
    output reg o_primary_system_err_n,
    output reg o_primary_system_err_oe,
    // forwarded parity flags toward the opposite bus, and the interrupt request
    output reg o_fwd_bad_to_sec,
    output reg o_fwd_bad_to_pri,
    output reg o_irq
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [`BWP_CTRL_W-1:0] ctrl;
reg [`BWP_ST_W-1:0] status;
reg [`BWP_ST_W-1:0] irq_mask;
reg [`BWP_ST_W-1:0] next_status;
reg [2:0] pri_pin_sync;
reg [2:0] sec_pin_sync;
reg pri_pin_seen;
reg sec_pin_seen;
reg [`BWP_PERR_DELAY-1:0] pri_perr_pipe;
reg [`BWP_PERR_DELAY-1:0] sec_perr_pipe;
reg pri_serr_req;

wire pri_per_en = ctrl[`BWP_CTRL_PRI_PER_EN];
wire sec_per_en = ctrl[`BWP_CTRL_SEC_PER_EN];
wire serr_en = ctrl[`BWP_CTRL_SERR_EN];
wire pw_serr_dis = ctrl[`BWP_CTRL_PW_SERR_DIS];

// bus decode helper
function is_addr;
    input [7:0] adr;
    input [7:0] ref_adr;
    begin
        is_addr = (adr[7:2] == ref_adr[7:2]);
    end
endfunction

wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// target reports arrive asynchronously, counted once stages two and three agree
always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        pri_pin_sync <= 3'h7;
        sec_pin_sync <= 3'h7;
        pri_pin_seen <= 1'b0;
        sec_pin_seen <= 1'b0;
    end else begin
        pri_pin_sync <= {pri_pin_sync[1:0], i_primary_parity_err_n};
        sec_pin_sync <= {sec_pin_sync[1:0], i_secondary_parity_err_n};
        if (pri_pin_sync[1] == pri_pin_sync[2]) begin
            pri_pin_seen <= ~pri_pin_sync[2];
        end
        if (sec_pin_sync[1] == sec_pin_sync[2]) begin
            sec_pin_seen <= ~sec_pin_sync[2];
        end
    end
end

// rising edge of a target report, ignoring our own drive
reg pri_pin_seen_d;
reg sec_pin_seen_d;
always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        pri_pin_seen_d <= 1'b0;
        sec_pin_seen_d <= 1'b0;
    end else begin
        pri_pin_seen_d <= pri_pin_seen;
        sec_pin_seen_d <= sec_pin_seen;
    end
end
wire pri_report = pri_pin_seen & ~pri_pin_seen_d & ~o_primary_parity_err_oe;
wire sec_report = sec_pin_seen & ~sec_pin_seen_d & ~o_secondary_parity_err_oe;

// ----------------------------------------
// event decode
// ----------------------------------------
// bridge is target of a write, or master of a read, on that bus
wire pri_det_ok = i_pri_phase & i_pri_par_bad & (i_pri_is_write ^ i_pri_bridge_master);
wire sec_det_ok = i_sec_phase & i_sec_par_bad & (i_sec_is_write ^ i_sec_bridge_master);
// bridge as master, read or write not decoded, to a target which reports
wire sec_tgt_rep = sec_report & i_sec_bridge_master;
wire pri_tgt_rep = pri_report & i_pri_bridge_master;

always @* begin
    next_status = status;
    if (wb_wr && is_addr(i_wb_adr, `BWP_ADDR_STATUS)) begin
        next_status = status & ~i_wb_dat[`BWP_ST_W-1:0];
    end
    if (pri_det_ok) begin
        next_status[`BWP_ST_PRI_DET] = 1'b1;
    end
    if (sec_det_ok) begin
        next_status[`BWP_ST_SEC_DET] = 1'b1;
    end
    if (pri_per_en && i_pri_bridge_master && i_pri_phase &&
        ((i_pri_par_bad && !i_pri_is_write) || pri_report)) begin
        next_status[`BWP_ST_PRI_MDPD] = 1'b1;
    end
    if (sec_per_en && i_sec_bridge_master && i_sec_phase &&
        ((i_sec_par_bad && !i_sec_is_write) || sec_report)) begin
        next_status[`BWP_ST_SEC_MDPD] = 1'b1;
    end
    if (pri_serr_req) begin
        next_status[`BWP_ST_SIG_SERR] = 1'b1;
    end
end

// system error on target report of unforwarded error
always @* begin
    pri_serr_req = 1'b0;
    if (serr_en && pri_per_en && sec_per_en) begin
        if (sec_tgt_rep && i_sec_phase && !pw_serr_dis && !i_sec_fwd_bad) begin
            pri_serr_req = 1'b1;
        end
        if (pri_tgt_rep && i_pri_phase && !i_pri_fwd_bad) begin
            pri_serr_req = 1'b1;
        end
    end
end

// ----------------------------------------
// status, pins and forwarding
// ----------------------------------------
always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        status <= `BWP_STATUS_RESET;
        pri_perr_pipe <= {`BWP_PERR_DELAY{1'b0}};
        sec_perr_pipe <= {`BWP_PERR_DELAY{1'b0}};
        o_primary_parity_err_n <= 1'b1;
        o_primary_parity_err_oe <= 1'b0;
        o_secondary_parity_err_n <= 1'b1;
        o_secondary_parity_err_oe <= 1'b0;
        o_primary_system_err_n <= 1'b1;
        o_primary_system_err_oe <= 1'b0;
        o_fwd_bad_to_sec <= 1'b0;
        o_fwd_bad_to_pri <= 1'b0;
        o_irq <= 1'b0;
    end else begin
        status <= next_status;
        // primary pin two cycles after the data phase
        pri_perr_pipe <= {pri_perr_pipe[`BWP_PERR_DELAY-2:0], pri_det_ok & pri_per_en};
        o_primary_parity_err_n <= ~pri_perr_pipe[`BWP_PERR_DELAY-2];
        o_primary_parity_err_oe <= pri_perr_pipe[`BWP_PERR_DELAY-2];
        // secondary pin two cycles after the data phase
        sec_perr_pipe <= {sec_perr_pipe[`BWP_PERR_DELAY-2:0], sec_det_ok & sec_per_en};
        o_secondary_parity_err_n <= ~sec_perr_pipe[`BWP_PERR_DELAY-2];
        o_secondary_parity_err_oe <= sec_perr_pipe[`BWP_PERR_DELAY-2];
        // open drain system error, one cycle low
        o_primary_system_err_n <= ~pri_serr_req;
        o_primary_system_err_oe <= pri_serr_req;
        // bad parity passed downstream, no retry
        o_fwd_bad_to_sec <= i_pri_phase & i_pri_par_bad & i_pri_is_write & ~i_pri_bridge_master;
        // bad parity passed upstream, no retry
        o_fwd_bad_to_pri <= i_sec_phase & i_sec_par_bad & i_sec_is_write & ~i_sec_bridge_master;
        o_irq <= |(next_status & irq_mask);
    end
end

// ----------------------------------------
// wishbone slave
// ----------------------------------------
always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
        ctrl <= `BWP_CTRL_RESET;
        irq_mask <= `BWP_MASK_RESET;
        o_wb_ack <= 1'b0;
        o_wb_dat <= 32'h0000_0000;
    end else begin
        o_wb_ack <= wb_req;
        if (wb_wr && is_addr(i_wb_adr, `BWP_ADDR_CTRL)) begin
            ctrl <= i_wb_dat[`BWP_CTRL_W-1:0];
        end
        if (wb_wr && is_addr(i_wb_adr, `BWP_ADDR_IRQ_MASK)) begin
            irq_mask <= i_wb_dat[`BWP_ST_W-1:0];
        end
        o_wb_dat <= 32'h0000_0000;
        if (wb_req && !i_wb_we) begin
            if (is_addr(i_wb_adr, `BWP_ADDR_CTRL)) begin
                o_wb_dat <= {28'h0000000, ctrl};
            end else if (is_addr(i_wb_adr, `BWP_ADDR_STATUS)) begin
                o_wb_dat <= {27'h0000000, status};
            end else if (is_addr(i_wb_adr, `BWP_ADDR_IRQ_MASK)) begin
                o_wb_dat <= {27'h0000000, irq_mask};
            end else if (is_addr(i_wb_adr, `BWP_ADDR_EVENTS)) begin
                o_wb_dat <= {30'h00000000, pri_pin_seen, sec_pin_seen};
            end
        end
    end
end

endmodule

// ===== sim/bwp_parity_report_checker.sv
// checker: parity pin timing, forwarding, system error gating
// assumes: bound to bwp_parity_report, one clock domain
`timescale 1ns/10ps
module bwp_parity_report_checker (
    input wire i_mclk,
    input wire i_reset_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire o_wb_ack,
    input wire i_pri_phase,
    input wire i_pri_par_bad,
    input wire i_pri_bridge_master,
    input wire i_pri_is_write,
    input wire i_sec_phase,
    input wire i_sec_par_bad,
    input wire i_sec_bridge_master,
    input wire i_sec_is_write,
    input wire o_primary_parity_err_n,
    input wire o_primary_parity_err_oe,
    input wire o_secondary_parity_err_n,
    input wire o_fwd_bad_to_sec,
    input wire o_fwd_bad_to_pri,
    input wire o_primary_system_err_n
);
    // -------------------------------
    // control shadow
    // -------------------------------
    reg [3:0] ctrl;
    wire pt = i_pri_phase && i_pri_par_bad && i_pri_is_write && !i_pri_bridge_master;
    wire st = i_sec_phase && i_sec_par_bad && i_sec_is_write && !i_sec_bridge_master;
    always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) ctrl <= 4'h0;
        else if (o_wb_ack && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0]) ctrl <= i_wb_dat[3:0];
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // -------------------------------
    // assertions
    // -------------------------------
    a_pri_perr_low: assert property (pt && ctrl[0] |-> ##2 !o_primary_parity_err_n && o_primary_parity_err_oe)
        else $error("primary pin not low");
    a_pri_perr_off: assert property (i_pri_phase && !ctrl[0] |-> ##2 o_primary_parity_err_n)
        else $error("primary pin without enable");
    a_pri_perr_cause: assert property (o_primary_parity_err_oe |-> $past(i_pri_phase && i_pri_par_bad, 2))
        else $error("primary pin without bad phase");
    a_sec_perr_low: assert property (st && ctrl[1] |-> ##2 !o_secondary_parity_err_n)
        else $error("secondary pin not low");
    a_fwd_down: assert property (pt |=> o_fwd_bad_to_sec)
        else $error("bad parity not forwarded down");
    a_fwd_up: assert property (st |=> o_fwd_bad_to_pri)
        else $error("bad parity not forwarded up");
    a_serr_gate: assert property (!o_primary_system_err_n |-> ctrl[2] && ctrl[1] && ctrl[0])
        else $error("system error without enables");
    a_wb_ack_once: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not one cycle");
    c_pri_pin: cover property (pt && ctrl[0]);
    c_sec_pin: cover property (st && ctrl[1]);
    c_serr: cover property (!o_primary_system_err_n);
endmodule
bind bwp_parity_report bwp_parity_report_checker u_chk (.*);

// ===== sim/bwp_bus_model.sv
// far-side target: reports bad write data on its parity pin
// assumes: pin pulled up, resolved with the bridge drive
`timescale 1ns/10ps
module bwp_bus_model (
    input wire i_mclk,
    input wire i_report,
    input wire i_drv_n,
    input wire i_drv_oe,
    output wire o_pin_n
);
    reg [1:0] dly = 2'h0;
    always @(posedge i_mclk) dly <= {dly[0], i_report};
    // held low two cycles so the three-flop filter keeps it
    assign o_pin_n = !(dly[0] || dly[1] || (i_drv_oe && !i_drv_n));
endmodule

// ===== sim/bwp_parity_report_tb_top.sv
// bench: register bus, parity phases, far-side reports
// assumes: 100 ns clock, register map of bwp_regs.vh
`timescale 1ns/10ps
`include "bwp_regs.vh"
module bwp_parity_report_tb_top;
    typedef struct {logic [3:0] c; int s; logic m; logic w; logic [4:0] e;} bwp_row_t;
    logic i_mclk = 1'h0, i_reset_n = 1'h0, req = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q;
    logic [1:0] ph = 2'h0, bad = 2'h0, mst = 2'h0, wr = 2'h0, fw = 2'h0, rep = 2'h0;
    wire ack, irq, pn, poe, sn, soe, yn, pin_p, pin_s;
    wire [31:0] rd;
    int errors = 0, checks_done = 0, serr = 0;
    bwp_row_t rows[9] = '{'{4'h1, 0, 0, 1, 5'h01}, '{4'h0, 0, 0, 1, 5'h01},
        '{4'h2, 1, 0, 1, 5'h02}, '{4'h0, 1, 0, 1, 5'h02}, '{4'h1, 0, 1, 0, 5'h05},
        '{4'h0, 0, 1, 0, 5'h01}, '{4'h2, 1, 1, 0, 5'h0a}, '{4'h3, 0, 0, 0, 5'h00},
        '{4'h3, 0, 1, 1, 5'h00}};
    always #50 i_mclk = ~i_mclk;
    always @(negedge i_mclk) if (yn === 1'h0) serr++;
    bwp_parity_report u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(req),
        .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat),
        .o_wb_dat(rd), .o_wb_ack(ack), .i_pri_phase(ph[0]), .i_pri_par_bad(bad[0]),
        .i_pri_bridge_master(mst[0]), .i_pri_is_write(wr[0]), .i_pri_fwd_bad(fw[0]),
        .i_sec_phase(ph[1]), .i_sec_par_bad(bad[1]), .i_sec_bridge_master(mst[1]),
        .i_sec_is_write(wr[1]), .i_sec_fwd_bad(fw[1]), .i_primary_parity_err_n(pin_p),
        .i_secondary_parity_err_n(pin_s), .o_primary_parity_err_n(pn),
        .o_primary_parity_err_oe(poe), .o_secondary_parity_err_n(sn),
        .o_secondary_parity_err_oe(soe), .o_primary_system_err_n(yn),
        .o_primary_system_err_oe(), .o_fwd_bad_to_sec(), .o_fwd_bad_to_pri(), .o_irq(irq));
    bwp_bus_model u_pm (.i_mclk(i_mclk), .i_report(rep[0]), .i_drv_n(pn), .i_drv_oe(poe),
        .o_pin_n(pin_p));
    bwp_bus_model u_sm (.i_mclk(i_mclk), .i_report(rep[1]), .i_drv_n(sn), .i_drv_oe(soe),
        .o_pin_n(pin_s));
    // -------------------------------
    // tasks
    // -------------------------------
    task wrap_up;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        req <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        cmp({31'h0, n < 20}, 32'h1);
        if (n >= 20) wrap_up;
        q = rd;
        req <= 1'h0;
    endtask
    task chk_irq(input logic e);
        repeat (2) @(negedge i_mclk);
        cmp({31'h0, irq}, {31'h0, e});
    endtask
    task phase(input int s, input logic m, w, b, f, r, input int len);
        @(posedge i_mclk);
        ph[s] <= 1'h1;
        mst[s] <= m;
        wr[s] <= w;
        bad[s] <= b;
        fw[s] <= f;
        rep[s] <= r;
        @(posedge i_mclk);
        rep <= 2'h0;
        repeat (len - 1) @(posedge i_mclk);
        ph <= 2'h0;
        bad <= 2'h0;
        repeat (4) @(posedge i_mclk);
    endtask
    task report(input int s, input logic [3:0] c, input logic f, input logic [4:0] e, int n);
        bus(1'h1, `BWP_ADDR_CTRL, {28'h0, c});
        bus(1'h1, `BWP_ADDR_STATUS, 32'h1f);
        serr = 0;
        phase(s, 1'h1, 1'h1, 1'h0, f, 1'h1, 8);
        bus(1'h0, `BWP_ADDR_STATUS, 32'h0);
        cmp(q, {27'h0, e});
        cmp(32'(serr), 32'(n));
    endtask
    // -------------------------------
    // main sequence
    // -------------------------------
    initial begin
        repeat (20) @(posedge i_mclk);
        i_reset_n <= 1'h1;
        bus(1'h1, 8'h10, 32'hff);
        for (int a = 0; a < 20; a += 4) begin
            bus(1'h0, 8'(a), 32'h0);
            cmp(q, 32'h0);
        end
        phase(0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1);
        bus(1'h1, `BWP_ADDR_IRQ_MASK, 32'h1);
        chk_irq(1'h1);
        bus(1'h1, `BWP_ADDR_STATUS, 32'h1e);
        bus(1'h0, `BWP_ADDR_STATUS, 32'h0);
        cmp(q, 32'h1);
        bus(1'h1, `BWP_ADDR_IRQ_MASK, 32'h0);
        chk_irq(1'h0);
        bus(1'h1, `BWP_ADDR_STATUS, 32'h1);
        bus(1'h1, `BWP_ADDR_IRQ_MASK, 32'h1);
        chk_irq(1'h0);
        foreach (rows[i]) begin
            bus(1'h1, `BWP_ADDR_CTRL, {28'h0, rows[i].c});
            bus(1'h1, `BWP_ADDR_STATUS, 32'h1f);
            phase(rows[i].s, rows[i].m, rows[i].w, 1'h1, 1'h0, 1'h0, 1);
            bus(1'h0, `BWP_ADDR_STATUS, 32'h0);
            cmp(q, {27'h0, rows[i].e});
        end
        report(1, 4'h7, 1'h0, 5'h18, 1);
        report(1, 4'h7, 1'h1, 5'h08, 0);
        report(1, 4'hf, 1'h0, 5'h08, 0);
        report(1, 4'h5, 1'h0, 5'h00, 0);
        report(0, 4'hf, 1'h0, 5'h14, 1);
        report(0, 4'h7, 1'h1, 5'h04, 0);
        report(0, 4'h6, 1'h0, 5'h00, 0);
        wrap_up;
    end
    initial begin
        #2000000;
        cmp(32'h0, 32'h1);
        wrap_up;
    end
endmodule
